// ---- rtl/tsp_timer.sv ----
// Five-channel 16-bit timer with synchronization, PWM and reset-sync PWM.
// Summary of operation
// - Preset write reaches all synchronized counters
// - Sync-clear channel clears with source channel
// - Channels 0 to 4 may join sync
// - PWM pin rises on A, falls on B
// - Equal A and B leave pin unchanged
// - PWM mode selectable per channel
// - Clear on B, A above B: stays low
// - Clear on A, B above A: stays high
// - PWM counter clears by A, B, sync, none
// - Reset-sync mode makes three complementary pairs
// - Reset-sync mode takes pins, counts up
// - Pair pins mapped to channel 3 and 4
// - Channel 4 counter free, no compares
// - Channel 3 A match clears period counter
// - Pairs toggle on own match and clear
// - Buffers load at channel 3 A match
// - Match acts as counter leaves matching value
// - Match sets flag, interrupt when enabled
`timescale 1ns/100ps
module tsp_timer
(
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Compare match interrupt request.
    output logic MATCH_IRQ,
    // PWM pins; channel 3 and 4 A pins carry outputs 1 and 2 in reset-sync.
    output logic [4:0] PWM_PIN_A,
    output logic OUT1_INV_PIN,
    output logic OUT3_PIN,
    output logic OUT2_INV_PIN,
    output logic OUT3_INV_PIN
);

////////////////////////////////////////////////////////////////////////////
// State and decode.

tsp_pkg::tsp_state_s s_reg; // Registered state of the whole block.
tsp_pkg::tsp_state_s s_next; // Next state built by the comb process.
tsp_pkg::tsp_apb_s bus; // Bundled bus request.
logic [4:0] hit_a; // Compare match A, taken as the counter advances.
logic [4:0] hit_b; // Compare match B.
logic [4:0] own_clr; // Clear caused by the channel's own compare.
logic sync_src; // Some synchronized channel clears by its own compare.
logic [4:0] clr; // Final clear of each counter.
logic wr; // Write taking effect at this edge.
logic wr_ch_win; // Write lands in the per-channel window.
logic [2:0] wr_ch; // Channel addressed by the write.
logic preset_all; // Counter write fanned out to the sync group.
logic [2:0] tog; // Reset-sync pair toggles.
logic [7:0] ch_off; // Address relative to the channel window.

assign bus = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};
assign ch_off = bus.paddr - tsp_pkg::ADDR_CH_BASE;

// Read mux: returns the mapped bit in bit 32 and data below it.
function automatic logic [32:0] rd_word(input tsp_pkg::tsp_state_s s,
                                        input logic [7:0] a);
    logic [7:0] o;
    logic [2:0] c;
    o = a - tsp_pkg::ADDR_CH_BASE;
    c = o[6:4];
    rd_word = {1'b0, 32'h0000_0000};
    if (a == tsp_pkg::ADDR_START)
        rd_word = {1'b1, 27'h0, s.start};
    else if (a == tsp_pkg::ADDR_SYNC)
        rd_word = {1'b1, 27'h0, s.sync};
    else if (a == tsp_pkg::ADDR_MODE)
        rd_word = {1'b1, 25'h0, s.pwm, s.buf_en, s.rsync};
    else if (a == tsp_pkg::ADDR_STATUS)
        rd_word = {1'b1, 22'h0, s.flag_b, s.flag_a};
    else if (a == tsp_pkg::ADDR_IRQEN)
        rd_word = {1'b1, 22'h0, s.irq_en};
    else if (a >= tsp_pkg::ADDR_CH_BASE && a <= tsp_pkg::ADDR_CH_END
             && a[1:0] == 2'h0)
    begin
        case (o[3:0])
            tsp_pkg::OFS_CTRL: rd_word = {1'b1, 30'h0, s.clr_sel[c]};
            tsp_pkg::OFS_COUNT: rd_word = {1'b1, 16'h0, s.cnt[c]};
            tsp_pkg::OFS_MA: rd_word = {1'b1, 16'h0, s.ma[c]};
            default: rd_word = {1'b1, 16'h0, s.mb[c]};
        endcase
    end
    else if (a >= tsp_pkg::ADDR_BUF_BASE && a <= tsp_pkg::ADDR_BUF_END
             && a[1:0] == 2'h0)
        rd_word = {1'b1, 16'h0, s.bufr[a[3:2]]};
endfunction

////////////////////////////////////////////////////////////////////////////
// Next-state logic.

// All behaviour is computed here from the registered state. Writes from the
// bus override counting so a preset is never lost to an increment.
always_comb
begin
    logic [32:0] rd;
    rd = rd_word(s_reg, bus.paddr);
    s_next = s_reg;
    wr = bus.psel & bus.penable & s_reg.pready & bus.pwrite;
    wr_ch_win = bus.paddr >= tsp_pkg::ADDR_CH_BASE
                && bus.paddr <= tsp_pkg::ADDR_CH_END;
    wr_ch = ch_off[6:4];
    preset_all = wr && wr_ch_win && ch_off[3:0] == tsp_pkg::OFS_COUNT
                 && s_reg.sync[wr_ch];

    // Matches count only on the edge where the counter steps on.
    for (int i = 0; i < tsp_pkg::NCH; i++)
    begin
        hit_a[i] = s_reg.start[i] && s_reg.cnt[i] == s_reg.ma[i];
        hit_b[i] = s_reg.start[i] && s_reg.cnt[i] == s_reg.mb[i];
    end
    // Channel 4 loses its compares in reset-sync mode.
    if (s_reg.rsync)
    begin
        hit_a[4] = 1'b0;
        hit_b[4] = 1'b0;
    end
    // Own clears by compare, any channel 0 to 4.
    for (int i = 0; i < tsp_pkg::NCH; i++)
        own_clr[i] = (s_reg.clr_sel[i] == tsp_pkg::CLR_A && hit_a[i])
                  || (s_reg.clr_sel[i] == tsp_pkg::CLR_B && hit_b[i]);
    sync_src = |(own_clr & s_reg.sync);
    for (int i = 0; i < tsp_pkg::NCH; i++)
        clr[i] = own_clr[i] || (s_reg.clr_sel[i] == tsp_pkg::CLR_SYNC
                 && s_reg.sync[i] && sync_src);
    // Reset-sync: A3 sets the period, channel 4 runs free.
    if (s_reg.rsync)
    begin
        clr[3] = hit_a[3];
        clr[4] = 1'b0;
    end

    // Counters step up, or restart from zero on a clear.
    for (int i = 0; i < tsp_pkg::NCH; i++)
        if (s_reg.start[i])
            s_next.cnt[i] = clr[i] ? tsp_pkg::CNT_RST
                                   : s_reg.cnt[i] + 16'h0001;

    // Compare flags: a new match wins over a clear in the same cycle.
    s_next.flag_a = s_reg.flag_a | hit_a;
    s_next.flag_b = s_reg.flag_b | hit_b;
    if (wr && bus.paddr == tsp_pkg::ADDR_STATUS)
    begin
        s_next.flag_a = (s_reg.flag_a & ~bus.pwdata[4:0]) | hit_a;
        s_next.flag_b = (s_reg.flag_b & ~bus.pwdata[9:5]) | hit_b;
    end

    // Plain PWM per channel; equal registers hold the pin.
    for (int i = 0; i < tsp_pkg::NCH; i++)
        if (s_reg.pwm[i] && !(s_reg.rsync && i >= 3))
        begin
            if (hit_a[i] && hit_b[i])
                s_next.pin_a[i] = s_reg.pin_a[i];
            else if (hit_a[i])
                s_next.pin_a[i] = 1'b1;
            else if (hit_b[i])
                s_next.pin_a[i] = 1'b0;
        end

    // Reset-sync pairs toggle on their edge register or the clear.
    tog[0] = s_reg.start[3] && s_reg.cnt[3] == s_reg.mb[3];
    tog[1] = s_reg.start[3] && s_reg.cnt[3] == s_reg.ma[4];
    tog[2] = s_reg.start[3] && s_reg.cnt[3] == s_reg.mb[4];
    tog = tog | {3{clr[3] && s_reg.rsync}};
    if (s_reg.rsync)
    begin
        // Six pins taken over; complements are exact inverses.
        s_next.pin_a[3] = s_reg.pin_a[3] ^ tog[0];
        s_next.pin_a[4] = s_reg.pin_a[4] ^ tog[1];
        s_next.pin_b4 = s_reg.pin_b4 ^ tog[2];
        s_next.pin_b3 = ~s_next.pin_a[3];
        s_next.pin_xa4 = ~s_next.pin_a[4];
        s_next.pin_xb4 = ~s_next.pin_b4;
    end
    else
    begin
        // Extra pins idle low outside reset-sync mode.
        s_next.pin_b3 = 1'b0;
        s_next.pin_b4 = 1'b0;
        s_next.pin_xa4 = 1'b0;
        s_next.pin_xb4 = 1'b0;
    end

    // Buffered registers load at the period match.
    if (s_reg.rsync && s_reg.buf_en && hit_a[3])
    begin
        s_next.ma[3] = s_reg.bufr[0];
        s_next.mb[3] = s_reg.bufr[1];
        s_next.ma[4] = s_reg.bufr[2];
        s_next.mb[4] = s_reg.bufr[3];
    end

    // Register writes at the completing access edge.
    if (wr)
    begin
        if (bus.paddr == tsp_pkg::ADDR_START)
            s_next.start = bus.pwdata[4:0];
        else if (bus.paddr == tsp_pkg::ADDR_SYNC)
            s_next.sync = bus.pwdata[4:0];
        else if (bus.paddr == tsp_pkg::ADDR_MODE)
        begin
            s_next.rsync = bus.pwdata[tsp_pkg::MODE_RSYNC_BIT];
            s_next.buf_en = bus.pwdata[tsp_pkg::MODE_BUF_BIT];
            s_next.pwm = bus.pwdata[tsp_pkg::MODE_PWM_LSB +: 5];
        end
        else if (bus.paddr == tsp_pkg::ADDR_IRQEN)
            s_next.irq_en = bus.pwdata[9:0];
        else if (bus.paddr >= tsp_pkg::ADDR_BUF_BASE
                 && bus.paddr <= tsp_pkg::ADDR_BUF_END)
            s_next.bufr[bus.paddr[3:2]] = bus.pwdata[15:0];
        else if (wr_ch_win)
        begin
            case (ch_off[3:0])
                tsp_pkg::OFS_CTRL: s_next.clr_sel[wr_ch] = bus.pwdata[1:0];
                tsp_pkg::OFS_COUNT:
                begin
                    // Fan the preset out to the whole group.
                    if (preset_all)
                    begin
                        for (int i = 0; i < tsp_pkg::NCH; i++)
                            if (s_reg.sync[i])
                                s_next.cnt[i] = bus.pwdata[15:0];
                    end
                    else
                        s_next.cnt[wr_ch] = bus.pwdata[15:0];
                end
                tsp_pkg::OFS_MA: s_next.ma[wr_ch] = bus.pwdata[15:0];
                tsp_pkg::OFS_MB: s_next.mb[wr_ch] = bus.pwdata[15:0];
                default: s_next.mb[wr_ch] = s_next.mb[wr_ch];
            endcase
        end
    end

    // Interrupt output follows the flags gated by their enables.
    s_next.irq = |({s_next.flag_b, s_next.flag_a} & s_reg.irq_en);

    // APB: data is fetched in the setup cycle, so one access cycle suffices.
    s_next.pready = bus.psel & ~bus.penable;
    s_next.pslverr = bus.psel & ~bus.penable & ~rd[32];
    s_next.prdata = (bus.psel & ~bus.penable) ? rd[31:0] : s_reg.prdata;
end

////////////////////////////////////////////////////////////////////////////
// State register.

// Every field resets to a constant; match registers start at all ones so
// that an unconfigured channel does not match early in its count.
always_ff @(posedge MCLK or posedge RST)
begin
    if (RST)
    begin
        s_reg <= '0;
        s_reg.ma <= {tsp_pkg::NCH{tsp_pkg::MATCH_RST}};
        s_reg.mb <= {tsp_pkg::NCH{tsp_pkg::MATCH_RST}};
        s_reg.prdata <= tsp_pkg::RDATA_RST;
    end
    else
        s_reg <= s_next;
end

// Outputs straight from the state flip-flops.
assign PRDATA = s_reg.prdata;
assign PREADY = s_reg.pready;
assign PSLVERR = s_reg.pslverr;
assign MATCH_IRQ = s_reg.irq;
assign PWM_PIN_A = s_reg.pin_a;
assign OUT1_INV_PIN = s_reg.pin_b3;
assign OUT3_PIN = s_reg.pin_b4;
assign OUT2_INV_PIN = s_reg.pin_xa4;
assign OUT3_INV_PIN = s_reg.pin_xb4;

////////////////////////////////////////////////////////////////////////////
// Checks.

default clocking cb @(posedge MCLK); endclocking
default disable iff (RST);

// A set edge on channel 0 is seen on its pin one cycle later.
sequence seq_set_a0;
    s_reg.pwm[0] && !s_reg.rsync && hit_a[0] && !hit_b[0];
endsequence

chk_sync_preset: assert property (preset_all && s_reg.sync[0]
    |=> s_reg.cnt[0] == $past(bus.pwdata[15:0]))
    else $error("Synchronized preset missed channel 0.");

chk_sync_clear: assert property (sync_src && !s_reg.rsync && !wr
    && s_reg.start[1] && s_reg.sync[1]
    && s_reg.clr_sel[1] == tsp_pkg::CLR_SYNC |=> s_reg.cnt[1] == 16'h0000)
    else $error("Synchronous clear missed channel 1.");

chk_pwm_set: assert property (seq_set_a0 |=> PWM_PIN_A[0])
    else $error("PWM pin did not rise on match A.");

chk_pwm_clear: assert property (s_reg.pwm[0] && !hit_a[0]
    && hit_b[0] |=> !PWM_PIN_A[0])
    else $error("PWM pin did not fall on match B.");

chk_pwm_equal: assert property (s_reg.pwm[0] && hit_a[0]
    && !s_reg.rsync && hit_b[0] |=> $stable(PWM_PIN_A[0]))
    else $error("Equal match registers changed the pin.");

chk_rsync_period: assert property (s_reg.rsync && hit_a[3]
    && !wr |=> s_reg.cnt[3] == 16'h0000)
    else $error("Period match did not clear channel 3.");

chk_rsync_inverse: assert property (s_reg.rsync |=>
    OUT1_INV_PIN == !PWM_PIN_A[3] && OUT2_INV_PIN == !PWM_PIN_A[4]
    && OUT3_INV_PIN == !OUT3_PIN)
    else $error("Complement pin is not the inverse.");

chk_rsync_toggle: assert property (s_reg.rsync && clr[3]
    |=> PWM_PIN_A[3] != $past(PWM_PIN_A[3])
    && OUT3_PIN != $past(OUT3_PIN))
    else $error("Pairs did not toggle at counter clear.");

chk_ch4_free: assert property (s_reg.rsync && s_reg.start[4]
    && !wr |=> s_reg.cnt[4] == $past(s_reg.cnt[4]) + 16'h0001)
    else $error("Channel 4 counter did not run free.");

// A write in the match cycle may change the enables, so it is left out.
chk_flag_set: assert property (hit_b[0] && !wr |=> s_reg.flag_b[0]
    && (!s_reg.irq_en[5] || MATCH_IRQ))
    else $error("Match flag or interrupt missing.");

chk_buf_load: assert property (s_reg.rsync && s_reg.buf_en
    && hit_a[3] && !wr |=> s_reg.mb[3] == $past(s_reg.bufr[1]))
    else $error("Buffer not loaded at period match.");

endmodule

// ---- rtl/tsp_pkg.sv ----
// Package of constants and types for the synchronized PWM timer block.
package tsp_pkg;
    // Channel count and counter width.
    localparam int NCH = 5;
    localparam int CW = 16;
    // Global register byte offsets.
    localparam logic [7:0] ADDR_START = 8'h00;
    localparam logic [7:0] ADDR_SYNC = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQEN = 8'h10;
    // Per-channel register window: base plus channel times stride.
    localparam logic [7:0] ADDR_CH_BASE = 8'h20;
    localparam logic [7:0] ADDR_CH_END = 8'h6c;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_COUNT = 4'h4;
    localparam logic [3:0] OFS_MA = 4'h8;
    localparam logic [3:0] OFS_MB = 4'hc;
    // Buffer registers for the reset-synchronized transfer.
    localparam logic [7:0] ADDR_BUF_BASE = 8'h80;
    localparam logic [7:0] ADDR_BUF_END = 8'h8c;
    // Mode register field positions.
    localparam int MODE_RSYNC_BIT = 0;
    localparam int MODE_BUF_BIT = 1;
    localparam int MODE_PWM_LSB = 2;
    // Status register field positions.
    localparam int STAT_FLAG_A_LSB = 0;
    localparam int STAT_FLAG_B_LSB = 5;
    // Values after reset.
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] MATCH_RST = 16'hffff;
    localparam logic [4:0] CH_RST = 5'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // Counter clear sources, held in the low bits of a channel's control.
    typedef enum logic [1:0] {CLR_NONE, CLR_A, CLR_B, CLR_SYNC} tsp_clr_e;
    // APB request as seen by the slave.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tsp_apb_s;
    // Whole state of the timer.
    typedef struct packed {
        logic [4:0] start;
        logic [4:0] sync;
        logic [4:0] pwm;
        logic rsync;
        logic buf_en;
        logic [4:0][1:0] clr_sel;
        logic [4:0][15:0] cnt;
        logic [4:0][15:0] ma;
        logic [4:0][15:0] mb;
        logic [3:0][15:0] bufr;
        logic [4:0] flag_a;
        logic [4:0] flag_b;
        logic [9:0] irq_en;
        logic irq;
        logic [4:0] pin_a;
        logic pin_b3;
        logic pin_b4;
        logic pin_xa4;
        logic pin_xb4;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tsp_state_s;
endpackage

// ---- verification/tsp_load_model.sv ----
// Load model that watches the PWM pins like an external gate driver.
`timescale 1ns/100ps
module tsp_load_model
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Pins seen by the load: five A pins and output 3, then complements.
    input wire logic [5:0] prim,
    input wire logic [2:0] inv,
    input wire logic inv_on,
    // Measurements for the bench.
    output logic [5:0][15:0] hi_len,
    output logic [5:0][15:0] edges,
    output logic [15:0] inv_err
);
    ////////////////////////////////////////////////////////////
    logic [5:0] prev; // Pin levels at the previous edge.
    logic [5:0][15:0] run; // Length of the high run in progress.

    // Sample at the rising edge, as a synchronous gate driver would.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev <= '0;
            run <= '0;
            hi_len <= '0;
            edges <= '0;
            inv_err <= '0;
        end
        else
        begin
            prev <= prim;
            for (int i = 0; i < 6; i++)
            begin
                // Every level change counts, so a stray glitch shows.
                if (prim[i] != prev[i])
                    edges[i] <= edges[i] + 16'h0001;
                if (prim[i])
                    run[i] <= prev[i] ? run[i] + 16'h0001 : 16'h0001;
                else if (prev[i])
                    hi_len[i] <= run[i];
            end
            // A pair that is not complementary would short the bridge.
            if (inv_on && inv != ~prim[5:3])
                inv_err <= inv_err + 16'h0001;
        end
    end
endmodule

// ---- verification/testbench.sv ----
// Self-checking testbench for the synchronized PWM timer.
`timescale 1ns/100ps
module testbench;
    ////////////////////////////////////////////////////////////
    logic mclk; // System clock, 25 MHz.
    logic rst; // Asynchronous reset, active high.
    logic psel; // APB request signals.
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata; // APB answer signals.
    logic pready;
    logic pslverr;
    logic irq; // Compare match interrupt.
    logic [4:0] pin_a; // PWM pins.
    logic inv1;
    logic out3;
    logic inv2;
    logic inv3;
    logic inv_on; // Complement watch enable.
    logic [5:0][15:0] hi_len; // Load measurements.
    logic [5:0][15:0] edges;
    logic [15:0] inv_err;
    logic [15:0] snap; // Edge count snapshot.
    logic [31:0] rd; // Last read data.
    logic [31:0] c0; // Saved counter value.
    logic rd_err; // Last error response.
    int err_count;
    int checked;

    tsp_timer i_dut (.MCLK(mclk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MATCH_IRQ(irq), .PWM_PIN_A(pin_a),
        .OUT1_INV_PIN(inv1), .OUT3_PIN(out3), .OUT2_INV_PIN(inv2),
        .OUT3_INV_PIN(inv3));
    tsp_load_model i_load (.clk(mclk), .rst(rst), .prim({out3, pin_a}),
        .inv({inv3, inv2, inv1}), .inv_on(inv_on), .hi_len(hi_len),
        .edges(edges), .inv_err(inv_err));

    // Free-running clock, 40 ns period.
    always #20 mclk = ~mclk;

    ////////////////////////////////////////////////////////////
    // One APB transfer; the request holds until PREADY is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // No wait state count is assumed; the watchdog ends a hang.
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compare and report at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Byte address of a register in a channel's window.
    function automatic logic [7:0] ca(input int ch, input logic [3:0] o);
        return tsp_pkg::ADDR_CH_BASE + 8'(16 * ch) + {4'h0, o};
    endfunction

    // Single place where the run ends.
    task automatic wrap_up();
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog; the whole sequence needs well under 3000 cycles.
    initial
    begin
        repeat (8000) @(posedge mclk);
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        wrap_up();
    end

    ////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, inv_on} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err_count = 0;
        checked = 0;
        cyc(10);
        rst <= 1'b0;
        // Reset value and an unmapped address.
        rdc(ca(0, tsp_pkg::OFS_MA), 32'h0000_ffff);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk({31'h0, rd_err}, 32'h1);
        chk(rd, 32'h0);
        // Preset on one channel lands on all grouped counters.
        wr(tsp_pkg::ADDR_SYNC, 32'h1f);
        wr(ca(2, tsp_pkg::OFS_COUNT), 32'h0100);
        for (int ch = 0; ch < 5; ch++)
            rdc(ca(ch, tsp_pkg::OFS_COUNT), 32'h0100);
        // Channel 1 clears together with channel 0 on its B match.
        wr(tsp_pkg::ADDR_SYNC, 32'h03);
        wr(ca(0, tsp_pkg::OFS_CTRL), 32'h2);
        wr(ca(0, tsp_pkg::OFS_MB), 32'h20);
        wr(ca(1, tsp_pkg::OFS_CTRL), 32'h3);
        wr(ca(0, tsp_pkg::OFS_COUNT), 32'h0);
        wr(tsp_pkg::ADDR_IRQEN, 32'h20);
        wr(tsp_pkg::ADDR_START, 32'h03);
        cyc(100);
        wr(tsp_pkg::ADDR_START, 32'h00);
        apb(1'b0, ca(0, tsp_pkg::OFS_COUNT), 32'h0);
        c0 = rd;
        chk({31'h0, c0 <= 32'h20}, 32'h1);
        rdc(ca(1, tsp_pkg::OFS_COUNT), c0);
        apb(1'b0, tsp_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h20, 32'h20);
        chk({31'h0, irq}, 32'h1);
        wr(tsp_pkg::ADDR_STATUS, 32'h3ff);
        cyc(3);
        chk({31'h0, irq}, 32'h0);
        rdc(tsp_pkg::ADDR_STATUS, 32'h0);
        // PWM on every channel, each with its own duty.
        wr(tsp_pkg::ADDR_SYNC, 32'h0);
        wr(tsp_pkg::ADDR_MODE, 32'h7c);
        for (int ch = 0; ch < 5; ch++)
        begin
            wr(ca(ch, tsp_pkg::OFS_CTRL), 32'h2);
            wr(ca(ch, tsp_pkg::OFS_MA), 32'(ch + 2));
            wr(ca(ch, tsp_pkg::OFS_MB), 32'h0f);
            wr(ca(ch, tsp_pkg::OFS_COUNT), 32'h0);
        end
        wr(tsp_pkg::ADDR_START, 32'h1f);
        cyc(80);
        for (int ch = 0; ch < 5; ch++)
            chk({16'h0, hi_len[ch]}, 32'(13 - ch));
        // Clear on A with B above A holds the pin high.
        wr(ca(0, tsp_pkg::OFS_CTRL), 32'h1);
        wr(ca(0, tsp_pkg::OFS_MA), 32'h08);
        wr(ca(0, tsp_pkg::OFS_MB), 32'h0c);
        wr(ca(0, tsp_pkg::OFS_COUNT), 32'h0);
        cyc(30);
        snap = edges[0];
        cyc(40);
        chk({16'h0, edges[0]}, {16'h0, snap});
        chk({31'h0, pin_a[0]}, 32'h1);
        // Equal A and B leave the level alone.
        wr(ca(0, tsp_pkg::OFS_MB), 32'h08);
        cyc(20);
        snap = edges[0];
        cyc(40);
        chk({16'h0, edges[0]}, {16'h0, snap});
        chk({31'h0, pin_a[0]}, 32'h1);
        // Clear on B with A above B holds the pin low.
        wr(ca(0, tsp_pkg::OFS_CTRL), 32'h2);
        wr(ca(0, tsp_pkg::OFS_MA), 32'h0c);
        wr(ca(0, tsp_pkg::OFS_COUNT), 32'h0);
        cyc(20);
        snap = edges[0];
        cyc(40);
        chk({16'h0, edges[0]}, {16'h0, snap});
        chk({31'h0, pin_a[0]}, 32'h0);
        // Reset in mid-run, then reset-synchronized PWM from clean pins.
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        wr(tsp_pkg::ADDR_MODE, 32'h01);
        wr(ca(3, tsp_pkg::OFS_MA), 32'h1f);
        wr(ca(3, tsp_pkg::OFS_MB), 32'h04);
        wr(ca(4, tsp_pkg::OFS_MA), 32'h08);
        wr(ca(4, tsp_pkg::OFS_MB), 32'h10);
        wr(ca(3, tsp_pkg::OFS_COUNT), 32'h0);
        wr(tsp_pkg::ADDR_START, 32'h18);
        cyc(50);
        inv_on <= 1'b1;
        wr(tsp_pkg::ADDR_STATUS, 32'h3ff);
        cyc(100);
        // Pins start low, so each primary is high from the cycle after
        // its edge match up to the period clear: 31 minus its edge.
        chk({16'h0, hi_len[3]}, 32'd27);
        chk({16'h0, hi_len[4]}, 32'd23);
        chk({16'h0, hi_len[5]}, 32'd15);
        apb(1'b0, ca(3, tsp_pkg::OFS_COUNT), 32'h0);
        chk({31'h0, rd <= 32'h1f}, 32'h1);
        apb(1'b0, ca(4, tsp_pkg::OFS_COUNT), 32'h0);
        chk({31'h0, rd > 32'h20}, 32'h1);
        apb(1'b0, tsp_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h218, 32'h8);
        // Buffered change of the pair 1 edge at the period match.
        wr(tsp_pkg::ADDR_BUF_BASE, 32'h1f);
        wr(8'h88, 32'h08);
        wr(8'h8c, 32'h10);
        wr(8'h84, 32'h06);
        wr(tsp_pkg::ADDR_MODE, 32'h03);
        cyc(100);
        chk({16'h0, hi_len[3]}, 32'd25);
        rdc(ca(3, tsp_pkg::OFS_MB), 32'h06);
        chk({16'h0, inv_err}, 32'h0);
        wrap_up();
    end
endmodule
